// *** rtl/tcu_capture.sv ***
// capture unit top with ahb-lite register slave
`timescale 1ns/100ps
module tcu_capture (
    // clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // ahb-lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic [31:0]                      hrdata,
    output logic                             hresp,
    // timer and pin
    input  wire logic [tcu_pkg::TIMER_W-1:0] timer_count_reg,
    input  wire logic                        capture_compare_pin_in,
    output logic                             capture_compare_pin_out,
    output logic                             capture_compare_pin_oe,
    // interrupt
    output logic                             irq
);
    tcu_evt_if ev ();

    tcu_edge_sync u_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  (capture_compare_pin_in),
        .ev      (ev)
    );

    tcu_presc u_presc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ev      (ev)
    );

    // register state
    logic [tcu_pkg::CTRL_W-1:0]  ctrl_reg;
    logic [tcu_pkg::CTRL_W-1:0]  ctrl_next;
    logic [tcu_pkg::TIMER_W-1:0] capture_value_reg;
    logic [tcu_pkg::TIMER_W-1:0] capture_value_next;
    logic                        capture_event_flag;
    logic                        flag_next;
    logic                        irq_en_reg;
    logic                        irq_en_next;
    logic                        irq_reg;
    logic                        irq_next;
    logic [2:0]                  mode_prev_reg;
    logic [2:0]                  mode_prev_next;
    logic                        pin_out_reg;
    logic                        pin_out_next;
    logic                        pin_oe_reg;
    logic                        pin_oe_next;

    // bus state
    logic                        wr_pend_reg;
    logic                        wr_pend_next;
    logic [tcu_pkg::ADDR_W-1:0]  waddr_reg;
    logic [tcu_pkg::ADDR_W-1:0]  waddr_next;
    logic [31:0]                 rdata_reg;
    logic [31:0]                 rdata_next;
    logic                        ready_reg;
    logic                        resp_reg;

    // decoded fields
    logic                        accept;
    logic [tcu_pkg::ADDR_W-1:0]  aaddr;
    logic [2:0]                  mode;
    logic                        enabled;
    logic                        out_mode;
    logic                        wr_ctrl;
    logic                        wr_clear;
    logic                        wr_enable;
    logic [15:0]                 cap_high_byte;
    logic [15:0]                 cap_low_byte;

    assign mode     = ctrl_reg[tcu_pkg::CTRL_MODE_MSB:tcu_pkg::CTRL_MODE_LSB];
    assign enabled  = ctrl_reg[tcu_pkg::CTRL_EN_BIT];
    assign out_mode = (mode == tcu_pkg::MODE_COMPARE) || (mode == tcu_pkg::MODE_PWM);
    assign accept   = hsel && htrans[1] && hready;
    assign aaddr    = haddr[tcu_pkg::ADDR_W-1:0];

    // event path control, capture blocked in output modes
    assign ev.mode = mode;
    assign ev.clr  = !enabled || out_mode || (mode != mode_prev_reg);

    // bus address and data phases
    always_comb begin
        wr_pend_next = accept && hwrite;
        waddr_next   = accept ? aaddr : waddr_reg;
        rdata_next   = 32'h0000_0000;
        if (accept && !hwrite) begin
            case (aaddr)
                tcu_pkg::ADDR_CTRL:   rdata_next = {26'h0, ctrl_reg};
                tcu_pkg::ADDR_CAPVAL: rdata_next = {16'h0, capture_value_reg};
                tcu_pkg::ADDR_STATUS: rdata_next = {31'h0, capture_event_flag};
                tcu_pkg::ADDR_ENABLE: rdata_next = {31'h0, irq_en_reg};
                default:              rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            waddr_reg   <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
            ready_reg   <= 1'b1;
            resp_reg    <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            waddr_reg   <= waddr_next;
            rdata_reg   <= rdata_next;
            ready_reg   <= 1'b1;
            resp_reg    <= 1'b0;
        end
    end

    assign wr_ctrl   = wr_pend_reg && (waddr_reg == tcu_pkg::ADDR_CTRL);
    assign wr_clear  = wr_pend_reg && (waddr_reg == tcu_pkg::ADDR_CLEAR)
                       && hwdata[tcu_pkg::STAT_CAP_BIT];
    assign wr_enable = wr_pend_reg && (waddr_reg == tcu_pkg::ADDR_ENABLE);

    // capture value, flag and interrupt
    always_comb begin
        ctrl_next          = wr_ctrl ? hwdata[tcu_pkg::CTRL_W-1:0] : ctrl_reg;
        irq_en_next        = wr_enable ? hwdata[tcu_pkg::STAT_CAP_BIT] : irq_en_reg;
        mode_prev_next     = mode;
        capture_value_next = capture_value_reg;
        flag_next          = capture_event_flag;
        if (wr_clear) begin
            flag_next = 1'b0;
        end
        if (ev.capture) begin
            capture_value_next = timer_count_reg;
            flag_next          = 1'b1;
        end
        irq_next = flag_next && irq_en_next;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg           <= tcu_pkg::CTRL_RESET;
            irq_en_reg         <= 1'b0;
            mode_prev_reg      <= tcu_pkg::MODE_FALL;
            capture_value_reg  <= 16'h0000;
            capture_event_flag <= 1'b0;
            irq_reg            <= 1'b0;
        end else begin
            ctrl_reg           <= ctrl_next;
            irq_en_reg         <= irq_en_next;
            mode_prev_reg      <= mode_prev_next;
            capture_value_reg  <= capture_value_next;
            capture_event_flag <= flag_next;
            irq_reg            <= irq_next;
        end
    end

    // pin driver, released in capture modes
    always_comb begin
        pin_out_next = 1'b0;
        pin_oe_next  = 1'b0;
        if (enabled && out_mode) begin
            pin_out_next = ctrl_reg[tcu_pkg::CTRL_LVL_BIT];
            if (ctrl_reg[tcu_pkg::CTRL_OD_BIT]) begin
                pin_out_next = 1'b0;
                pin_oe_next  = !ctrl_reg[tcu_pkg::CTRL_LVL_BIT];
            end else begin
                pin_oe_next  = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg  <= 1'b0;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
        end
    end

    assign hreadyout               = ready_reg;
    assign hresp                   = resp_reg;
    assign hrdata                  = rdata_reg;
    assign irq                     = irq_reg;
    assign capture_compare_pin_out = pin_out_reg;
    assign capture_compare_pin_oe  = pin_oe_reg;

    // byte views kept for the consistency checks
    assign cap_high_byte = {8'h00, capture_value_reg[15:8]};
    assign cap_low_byte  = {8'h00, capture_value_reg[7:0]};

    sequence s_capture_taken;
        ev.capture ##1 capture_event_flag;
    endsequence

    AST_CAPTURE_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.capture |=> capture_value_reg == $past(timer_count_reg))
        else $error("captured value differs from timer count");
    AST_BYTES_MATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.capture |=> cap_high_byte[7:0] == $past(timer_count_reg[15:8])
                       && cap_low_byte[7:0] == $past(timer_count_reg[7:0]))
        else $error("captured bytes split");
    AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.capture |-> s_capture_taken)
        else $error("capture did not set flag");
    AST_FLAG_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        (capture_event_flag && !wr_clear) |=> capture_event_flag)
        else $error("flag dropped without clear");
    AST_FLAG_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_clear && !ev.capture) |=> !capture_event_flag)
        else $error("clear write ignored");
    AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_clear && ev.capture) |=> capture_event_flag)
        else $error("clear beat a simultaneous capture");
    AST_HOLD_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
        !ev.capture |=> $stable(capture_value_reg))
        else $error("capture value changed without event");
    AST_OPEN_DRAIN: assert property (@(posedge hclk) disable iff (!hresetn)
        (enabled && out_mode && ctrl_reg[tcu_pkg::CTRL_OD_BIT]
         && ctrl_reg[tcu_pkg::CTRL_LVL_BIT]) |=> !capture_compare_pin_oe)
        else $error("open-drain pin driven high");
    AST_NO_CAPTURE_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
        out_mode |-> !ev.capture)
        else $error("capture in output mode");
    AST_PIN_RELEASED: assert property (@(posedge hclk) disable iff (!hresetn)
        !(enabled && out_mode) |=> !capture_compare_pin_oe)
        else $error("pin driven in capture mode");
    AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 irq == (capture_event_flag && irq_en_reg))
        else $error("interrupt level mismatch");
endmodule

// *** rtl/tcu_edge_sync.sv ***
// input synchroniser and edge detector
`timescale 1ns/100ps
module tcu_edge_sync (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // pin
    input  wire logic pin_in,
    // events
    tcu_evt_if.edge_mp ev
);
    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic sync1_next;
    logic sync2_next;
    logic last_next;

    always_comb begin
        sync1_next = pin_in;
        sync2_next = sync1_reg;
        last_next  = sync2_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg  <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg  <= last_next;
        end
    end

    // one pulse per edge of the synchronised level
    assign ev.rise = sync2_reg & ~last_reg;
    assign ev.fall = ~sync2_reg & last_reg;

    AST_EDGE_SINGLE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ev.rise || ev.fall) |=> !(ev.rise || ev.fall))
        else $error("edge pulse longer than one cycle");
endmodule

// *** rtl/tcu_evt_if.sv ***
// event signals between edge detector, prescaler and top
`timescale 1ns/100ps
interface tcu_evt_if;
    logic       rise;
    logic       fall;
    logic [2:0] mode;
    logic       clr;
    logic       capture;
    modport edge_mp (output rise, output fall);
    modport presc_mp (input rise, input fall, input mode, input clr, output capture);
    modport ctrl_mp (input capture, output mode, output clr);
endinterface

// *** rtl/tcu_pkg.sv ***
// constants for the timer capture unit
package tcu_pkg;
    localparam int TIMER_W = 16;
    localparam int PRESC_W = 4;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CAPVAL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CLEAR  = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE = 8'h10;
    localparam int ADDR_W = 8;
    // control fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_MODE_MSB = 3;
    localparam int CTRL_OD_BIT   = 4;
    localparam int CTRL_LVL_BIT  = 5;
    localparam int CTRL_W        = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // status, clear and enable layout
    localparam int STAT_CAP_BIT = 0;
    // event select and output modes
    localparam logic [2:0] MODE_FALL    = 3'h0;
    localparam logic [2:0] MODE_RISE    = 3'h1;
    localparam logic [2:0] MODE_RISE4   = 3'h2;
    localparam logic [2:0] MODE_RISE16  = 3'h3;
    localparam logic [2:0] MODE_BOTH    = 3'h4;
    localparam logic [2:0] MODE_COMPARE = 3'h5;
    localparam logic [2:0] MODE_PWM     = 3'h6;
    // prescale terminal counts
    localparam logic [3:0] PRESC4_LAST  = 4'h3;
    localparam logic [3:0] PRESC16_LAST = 4'hf;
    localparam logic [3:0] PRESC_ZERO   = 4'h0;
endpackage

// *** rtl/tcu_presc.sv ***
// event select and edge prescaler
`timescale 1ns/100ps
module tcu_presc (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // events
    tcu_evt_if.presc_mp ev
);
    logic [tcu_pkg::PRESC_W-1:0] cnt_reg;
    logic [tcu_pkg::PRESC_W-1:0] cnt_next;
    logic [tcu_pkg::PRESC_W-1:0] last;
    logic                        cap;

    always_comb begin
        cnt_next = cnt_reg;
        cap      = 1'b0;
        last     = (ev.mode == tcu_pkg::MODE_RISE4) ? tcu_pkg::PRESC4_LAST
                                                    : tcu_pkg::PRESC16_LAST;
        if (ev.clr) begin
            cnt_next = tcu_pkg::PRESC_ZERO;
        end else begin
            case (ev.mode)
                tcu_pkg::MODE_FALL: cap = ev.fall;
                tcu_pkg::MODE_RISE: cap = ev.rise;
                tcu_pkg::MODE_BOTH: cap = ev.rise | ev.fall;
                tcu_pkg::MODE_RISE4, tcu_pkg::MODE_RISE16: begin
                    if (ev.rise) begin
                        if (cnt_reg == last) begin
                            cap      = 1'b1;
                            cnt_next = tcu_pkg::PRESC_ZERO;
                        end else begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                end
                default: cap = 1'b0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= tcu_pkg::PRESC_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign ev.capture = cap;

    AST_PRESC_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        ev.clr |=> cnt_reg == tcu_pkg::PRESC_ZERO)
        else $error("prescale counter not cleared");
    AST_RISE4_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ev.clr && ev.mode == tcu_pkg::MODE_RISE4 && ev.rise
         && cnt_reg == tcu_pkg::PRESC4_LAST) |-> ev.capture)
        else $error("fourth rising edge not captured");
    AST_FALL_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ev.clr && ev.mode == tcu_pkg::MODE_FALL) |-> ev.capture == ev.fall)
        else $error("falling mode capture mismatch");
endmodule

// *** verification/tb_tcu_capture.sv ***
// testbench for the timer capture unit
`timescale 1ns/100ps
module tb_tcu_capture;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [15:0] timer;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe;
    logic        irq;
    logic        drive_level;
    logic [31:0] rd;
    logic [15:0] t1;
    logic [15:0] t2;
    logic [2:0]  rmode [3] = '{tcu_pkg::MODE_RISE, tcu_pkg::MODE_RISE4, tcu_pkg::MODE_RISE16};
    int          rcnt [3]  = '{1, 4, 16};
    logic [2:0]  omode [4] = '{tcu_pkg::MODE_COMPARE, tcu_pkg::MODE_COMPARE,
                               tcu_pkg::MODE_PWM, tcu_pkg::MODE_PWM};
    logic [3:0]  otab [4]  = '{4'b0111, 4'b1100, 4'b1010, 4'b0010};
    int          miscompares;
    int          n_compared;
    int          cycles;

    tcu_capture tcu_capture_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timer_count_reg(timer),
        .capture_compare_pin_in(pin_in), .capture_compare_pin_out(pin_out),
        .capture_compare_pin_oe(pin_oe), .irq(irq));
    tcu_partner tcu_partner_inst (.hclk(hclk), .hresetn(hresetn), .drive_level(drive_level),
        .pin_out(pin_out), .pin_oe(pin_oe), .timer_count(timer), .pin_in(pin_in));

    initial hclk = 1'b0;
    always #2 hclk = ~hclk;

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("Error timeout expected 0 seen %0d", cycles);
            end_of_test();
        end
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_ready;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // one single ahb-lite transfer, called right after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        d = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rd);
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        ahb(1'b0, a, 32'h00000000, rd);
        cmp(nm, e, rd);
        cmp("hresp", 32'h0, {31'h0, hresp});
    endtask

    // pin change, returns timer seen in the cycle of the change
    task automatic pin_set(input logic v, output logic [15:0] t);
        drive_level <= v;
        #1 t = timer;
        repeat (6) @(posedge hclk);
    endtask

    task automatic pulse(output logic [15:0] tr);
        pin_set(1'b1, tr);
        pin_set(1'b0, t2);
    endtask

    function automatic logic [31:0] cw(logic [2:0] m, logic en, logic od, logic lvl);
        cw = 32'h00000000;
        cw[tcu_pkg::CTRL_EN_BIT] = en;
        cw[tcu_pkg::CTRL_MODE_MSB:tcu_pkg::CTRL_MODE_LSB] = m;
        cw[tcu_pkg::CTRL_OD_BIT] = od;
        cw[tcu_pkg::CTRL_LVL_BIT] = lvl;
    endfunction

    task automatic arm(input logic [2:0] m);
        wr(tcu_pkg::ADDR_CTRL, cw(m, 1'b1, 1'b0, 1'b0));
        wr(tcu_pkg::ADDR_CLEAR, 32'h00000001);
    endtask

    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, drive_level} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(tcu_pkg::ADDR_CTRL, 32'h00000000, "ctrl");
        chk(tcu_pkg::ADDR_STATUS, 32'h00000000, "status");
        chk(tcu_pkg::ADDR_ENABLE, 32'h00000000, "enable");
        chk(8'h20, 32'h00000000, "unmapped");
        cmp("irq", 32'h0, {31'h0, irq});
        cmp("pin oe", 32'h0, {31'h0, pin_oe});
        cmp("pin out", 32'h0, {31'h0, pin_out});
        cmp("hreadyout", 32'h1, {31'h0, hreadyout});
        wr(tcu_pkg::ADDR_CAPVAL, 32'h00001234);
        chk(tcu_pkg::ADDR_CAPVAL, 32'h00000000, "capval read only");
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            arm(rmode[i]);
            repeat (rcnt[i] - 1) pulse(t1);
            chk(tcu_pkg::ADDR_STATUS, 32'h0, "flag early");
            pulse(t1);
            chk(tcu_pkg::ADDR_STATUS, 32'h1, "flag");
            chk(tcu_pkg::ADDR_CAPVAL, {16'h0, t1 + 16'h0002}, "capval");
            wr(tcu_pkg::ADDR_CLEAR, 32'h00000001);
            chk(tcu_pkg::ADDR_STATUS, 32'h0, "single capture");
        end
        arm(tcu_pkg::MODE_FALL);
        pin_set(1'b1, t1);
        chk(tcu_pkg::ADDR_STATUS, 32'h0, "fall mode rise");
        pin_set(1'b0, t1);
        chk(tcu_pkg::ADDR_CAPVAL, {16'h0, t1 + 16'h0002}, "fall capval");
        $display("test edge modes done");
        arm(tcu_pkg::MODE_BOTH);
        wr(tcu_pkg::ADDR_ENABLE, 32'h00000001);
        pin_set(1'b1, t1);
        chk(tcu_pkg::ADDR_CAPVAL, {16'h0, t1 + 16'h0002}, "both rise");
        cmp("irq", 32'h1, {31'h0, irq});
        pin_set(1'b0, t1);
        chk(tcu_pkg::ADDR_CAPVAL, {16'h0, t1 + 16'h0002}, "overwrite");
        chk(tcu_pkg::ADDR_CAPVAL, {16'h0, t1 + 16'h0002}, "reread");
        repeat (20) @(posedge hclk);
        chk(tcu_pkg::ADDR_STATUS, 32'h1, "sticky");
        wr(tcu_pkg::ADDR_ENABLE, 32'h00000000);
        repeat (3) @(posedge hclk);
        cmp("irq masked", 32'h0, {31'h0, irq});
        wr(tcu_pkg::ADDR_ENABLE, 32'h00000001);
        repeat (3) @(posedge hclk);
        cmp("irq unmasked", 32'h1, {31'h0, irq});
        wr(tcu_pkg::ADDR_CLEAR, 32'h00000001);
        chk(tcu_pkg::ADDR_STATUS, 32'h0, "cleared");
        cmp("irq cleared", 32'h0, {31'h0, irq});
        // clear lands on the very edge that the capture does
        drive_level <= 1'b1;
        @(posedge hclk);
        wr(tcu_pkg::ADDR_CLEAR, 32'h00000001);
        repeat (4) @(posedge hclk);
        chk(tcu_pkg::ADDR_STATUS, 32'h1, "set wins");
        pin_set(1'b0, t1);
        $display("test flag done");
        for (int k = 0; k < 2; k++) begin
            arm(tcu_pkg::MODE_RISE4);
            pulse(t1);
            pulse(t1);
            wr(tcu_pkg::ADDR_CTRL, (k == 0) ? cw(tcu_pkg::MODE_RISE16, 1'b1, 1'b0, 1'b0) : 32'h0);
            wr(tcu_pkg::ADDR_CTRL, cw(tcu_pkg::MODE_RISE4, 1'b1, 1'b0, 1'b0));
            repeat (3) pulse(t1);
            chk(tcu_pkg::ADDR_STATUS, 32'h0, "prescale cleared");
            pulse(t1);
            chk(tcu_pkg::ADDR_STATUS, 32'h1, "prescale fourth");
        end
        $display("test prescale done");
        wr(tcu_pkg::ADDR_CLEAR, 32'h00000001);
        wr(tcu_pkg::ADDR_CTRL, cw(tcu_pkg::MODE_RISE, 1'b0, 1'b0, 1'b0));
        pulse(t1);
        chk(tcu_pkg::ADDR_STATUS, 32'h0, "disabled");
        wr(tcu_pkg::ADDR_CTRL, cw(3'h7, 1'b1, 1'b0, 1'b0));
        pulse(t1);
        chk(tcu_pkg::ADDR_STATUS, 32'h0, "mode none");
        // open-drain released high so the outside source reaches the input
        wr(tcu_pkg::ADDR_CTRL, cw(tcu_pkg::MODE_COMPARE, 1'b1, 1'b1, 1'b1));
        pulse(t1);
        chk(tcu_pkg::ADDR_STATUS, 32'h0, "output mode");
        for (int j = 0; j < 4; j++) begin
            wr(tcu_pkg::ADDR_CTRL, cw(omode[j], 1'b1, otab[j][3], otab[j][2]));
            repeat (3) @(posedge hclk);
            cmp("pin oe", {31'h0, otab[j][1]}, {31'h0, pin_oe});
            cmp("pin out", {31'h0, otab[j][0]}, {31'h0, pin_out});
        end
        $display("test pin driver done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        cmp("oe in reset", 32'h0, {31'h0, pin_oe});
        cmp("irq in reset", 32'h0, {31'h0, irq});
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(tcu_pkg::ADDR_CTRL, 32'h00000000, "ctrl after reset");
        chk(tcu_pkg::ADDR_STATUS, 32'h00000000, "status after reset");
        cmp("oe after reset", 32'h0, {31'h0, pin_oe});
        $display("test mid reset done");
        end_of_test();
    end
endmodule

// *** verification/tcu_partner.sv ***
// partner model: free-running timer and external capture source
`timescale 1ns/100ps
module tcu_partner #(
    parameter logic [tcu_pkg::TIMER_W-1:0] TIMER_START = 16'hfff0
) (
    // clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // bench request
    input  wire logic                        drive_level,
    // device side
    input  wire logic                        pin_out,
    input  wire logic                        pin_oe,
    output logic [tcu_pkg::TIMER_W-1:0]      timer_count,
    output logic                             pin_in
);
    // start near wrap so high bits move
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_count <= TIMER_START;
        end else begin
            timer_count <= timer_count + 16'h0001;
        end
    end
    // device drive wins, else external source drives the input
    assign pin_in = pin_oe ? pin_out : drive_level;
endmodule
